// ==== pkg/pfsp_consts.svh ====
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef PFSP_CONSTS_SVH
`define PFSP_CONSTS_SVH
`define PFSP_CLK_HZ          20000000
`define PFSP_EVENT_HZ        32000
`define PFSP_SETTLE_MS       100
`define PFSP_SETTLE_EVENTS   ((`PFSP_SETTLE_MS * `PFSP_EVENT_HZ) / 1000)
`define PFSP_BUS_OV_V        450
`define PFSP_BUS_UV_V        80
`define PFSP_IN_OV_V         388
`define PFSP_SW_OC_A         19
`define PFSP_HW_OC_CA        4909
`define PFSP_REG_CTRL        8'h00
`define PFSP_REG_MODE        8'h04
`define PFSP_REG_ERR         8'h08
`define PFSP_REG_IRQ_STAT    8'h0C
`define PFSP_REG_IRQ_MASK    8'h10
`define PFSP_REG_START_V     8'h14
`define PFSP_REG_VREF        8'h18
`define PFSP_CTRL_RELAY      0
`define PFSP_CTRL_CANCEL     1
`define PFSP_ERR_IN_OV       0
`define PFSP_ERR_BUS_OV      1
`define PFSP_ERR_BUS_UV      2
`define PFSP_ERR_SW_OC       3
`define PFSP_ERR_HW_OC       4
`define PFSP_ERR_HEAT        5
`define PFSP_IRQ_FAULT       0
`define PFSP_IRQ_ACTIVE      1
`define PFSP_START_V_RST     16'h0172
`define PFSP_RESP_OKAY       2'h0
`define PFSP_RESP_SLVERR     2'h2
`endif

// ==== pkg/pfsp_pkg.sv ====
// types shared by the sequencer files
package pfsp_pkg;
  typedef enum logic [4:0] {
    PFSP_IDLE   = 5'b00001,
    PFSP_RELAY  = 5'b00010,
    PFSP_RAMP   = 5'b00100,
    PFSP_ON     = 5'b01000,
    PFSP_ERROR  = 5'b10000
  } pfsp_state_t;

  typedef struct packed {
    logic [15:0] vac;
    logic [15:0] vdc;
    logic [15:0] ichp;
  } pfsp_sample_t;

  typedef struct packed {
    logic heat;
    logic hw_oc;
    logic sw_oc;
    logic bus_uv;
    logic bus_ov;
    logic in_ov;
  } pfsp_err_t;
endpackage : pfsp_pkg

// ==== core/pfsp_fault_check.sv ====
// per-event limit comparison of converter samples and the heat pin
`include "pfsp_consts.svh"
module pfsp_fault_check (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire logic                  sample_valid,
  input  wire pfsp_pkg::pfsp_sample_t sample,
  input  wire logic                  heat_ok,
  output pfsp_pkg::pfsp_err_t        found
);
  // samples are volts/amps as unsigned integers; a reached limit is a fault
  function automatic logic at_least(input logic [15:0] v,
                                    input logic [15:0] lim);
    at_least = v >= lim;
  endfunction : at_least

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      found <= '0;
    end else if (sample_valid) begin
      found.bus_ov <= at_least(sample.vdc, 16'(`PFSP_BUS_OV_V));
      found.bus_uv <= sample.vdc <= 16'(`PFSP_BUS_UV_V);
      found.in_ov  <= at_least(sample.vac, 16'(`PFSP_IN_OV_V));
      found.sw_oc  <= at_least(sample.ichp, 16'(`PFSP_SW_OC_A));
      found.heat   <= !heat_ok;
      found.hw_oc  <= 1'b0;
    end else begin
      found <= '0;
    end
  end
endmodule : pfsp_fault_check

// ==== core/pfsp_sequencer.sv ====
// startup sequencing and protective stop of the pfc stage
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`include "pfsp_consts.svh"
module pfsp_sequencer (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire logic                  adc_done,
  input  wire pfsp_pkg::pfsp_sample_t adc_sample,
  input  wire logic                  heat_ok_pin,
  input  wire logic                  hw_oc_irq_pin,
  input  wire logic                  relay_closed_pin,
  output logic                       relay_drive,
  output logic                       pfc_enable,
  output logic                       gate_enable,
  output logic                       inverter_stop,
  output logic                       pwm_as_gpio,
  output logic                       pwm_gpio_level,
  output logic                       irq,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);
  pfsp_pkg::pfsp_state_t state;
  pfsp_pkg::pfsp_state_t next_state;
  pfsp_pkg::pfsp_err_t   found;
  pfsp_pkg::pfsp_err_t   err;
  logic [1:0]  heat_sync;
  logic [2:0]  oc_sync;
  logic [1:0]  relay_sync;
  logic        relay_prev;
  logic        relay_req;
  logic        cancel_pulse;
  logic [15:0] start_v;
  logic [15:0] vref;
  logic [15:0] wait_cnt;
  logic [3:0]  w_strb;
  logic        step;
  logic        step_d;
  logic        fault_any;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  logic [1:0]  irq_evt;
  logic [7:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic        w_held;
  logic [15:0] vdc_last;

  // pins cross from outside; first stage read only by second
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      heat_sync  <= 2'h3;
      oc_sync    <= 3'h0;
      relay_sync <= 2'h0;
    end else begin
      heat_sync  <= {heat_sync[0], heat_ok_pin};
      oc_sync    <= {oc_sync[1:0], hw_oc_irq_pin};
      relay_sync <= {relay_sync[0], relay_closed_pin};
    end
  end

  assign step = adc_done;

  pfsp_fault_check u_check (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .sample_valid (step),
    .sample       (adc_sample),
    .heat_ok      (heat_sync[1]),
    .found        (found)
  );

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      step_d   <= 1'b0;
      vdc_last <= 16'h0000;
    end else begin
      step_d <= step;
      if (step) begin
        vdc_last <= adc_sample.vdc;
      end
    end
  end

  // rising edge of the comparator line is the hardware overcurrent event
  function automatic logic rose(input logic [2:0] s);
    rose = s[1] && !s[2];
  endfunction : rose

  // latching: a new fault wins over a cancel in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      err <= '0;
    end else begin
      err <= (cancel_pulse ? '0 : err) | found;
      if (rose(oc_sync)) begin
        err.hw_oc <= 1'b1;
      end
    end
  end

  assign fault_any = |err;

  always_comb begin
    next_state = state;
    unique case (state)
      pfsp_pkg::PFSP_IDLE: begin
        if (relay_sync[1] && !fault_any) begin
          next_state = pfsp_pkg::PFSP_RELAY;
        end
      end
      pfsp_pkg::PFSP_RELAY: begin
        if (vdc_last >= start_v && relay_sync[1] && !fault_any
            && wait_cnt == 16'h0000) begin
          next_state = pfsp_pkg::PFSP_RAMP;
        end
      end
      pfsp_pkg::PFSP_RAMP: begin
        if (vref >= start_v) begin
          next_state = pfsp_pkg::PFSP_ON;
        end
      end
      pfsp_pkg::PFSP_ON: begin
        next_state = pfsp_pkg::PFSP_ON;
      end
      pfsp_pkg::PFSP_ERROR: begin
        if (!fault_any) begin
          next_state = pfsp_pkg::PFSP_IDLE;
        end
      end
      default: next_state = pfsp_pkg::PFSP_ERROR;
    endcase
    if (fault_any) begin
      next_state = pfsp_pkg::PFSP_ERROR;
    end
    if (!relay_sync[1] && !fault_any
        && state != pfsp_pkg::PFSP_ERROR) begin
      next_state = pfsp_pkg::PFSP_IDLE;
    end
  end

  // steps advance the cycle after each event, when vdc_last and the comparison result land
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= pfsp_pkg::PFSP_IDLE;
    end else if (step_d || fault_any) begin
      state <= next_state;
    end
  end

  // settle count only armed by an open-to-closed relay change
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      relay_prev <= 1'b0;
      wait_cnt   <= 16'h0000;
    end else begin
      relay_prev <= relay_sync[1];
      if (relay_sync[1] && !relay_prev) begin
        wait_cnt <= 16'(`PFSP_SETTLE_EVENTS);
      end else if (step && wait_cnt != 16'h0000) begin
        wait_cnt <= wait_cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      relay_drive    <= 1'b0;
      pfc_enable     <= 1'b0;
      gate_enable    <= 1'b0;
      inverter_stop  <= 1'b1;
      pwm_as_gpio    <= 1'b1;
      pwm_gpio_level <= 1'b0;
    end else begin
      relay_drive    <= relay_req && !fault_any;
      pfc_enable     <= !fault_any && (state == pfsp_pkg::PFSP_RAMP
                        || state == pfsp_pkg::PFSP_ON);
      gate_enable    <= !fault_any && (state == pfsp_pkg::PFSP_RAMP
                        || state == pfsp_pkg::PFSP_ON);
      inverter_stop  <= fault_any;
      pwm_as_gpio    <= fault_any || !(state == pfsp_pkg::PFSP_RAMP
                        || state == pfsp_pkg::PFSP_ON);
      pwm_gpio_level <= 1'b0;
    end
  end

  function automatic logic [7:0] mode_code(input pfsp_pkg::pfsp_state_t s);
    unique case (s)
      pfsp_pkg::PFSP_IDLE:  mode_code = 8'h00;
      pfsp_pkg::PFSP_RELAY: mode_code = 8'h01;
      pfsp_pkg::PFSP_RAMP:  mode_code = 8'h02;
      pfsp_pkg::PFSP_ON:    mode_code = 8'h03;
      default:              mode_code = 8'h04;
    endcase
  endfunction : mode_code

  // write channel: address and data taken in either order
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PFSP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr <= `PFSP_REG_VREF && aw_addr[1:0] == 2'h0)
                        ? `PFSP_RESP_OKAY : `PFSP_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  wire wr_go = aw_held && w_held && !s_axi_bvalid;

  // writable control: relay request, cancel strobe, start level, command
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      relay_req    <= 1'b0;
      cancel_pulse <= 1'b0;
      start_v      <= `PFSP_START_V_RST;
      vref         <= 16'h0000;
      irq_mask     <= 2'h0;
    end else begin
      cancel_pulse <= 1'b0;
      if (wr_go && aw_addr == `PFSP_REG_CTRL && w_strb[0]) begin
        relay_req    <= w_data[`PFSP_CTRL_RELAY];
        cancel_pulse <= w_data[`PFSP_CTRL_CANCEL];
      end
      if (wr_go && aw_addr == `PFSP_REG_START_V) begin
        start_v <= w_data[15:0];
      end
      if (wr_go && aw_addr == `PFSP_REG_VREF) begin
        vref <= w_data[15:0];
      end
      if (wr_go && aw_addr == `PFSP_REG_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[1:0];
      end
    end
  end

  // sticky events; a new event beats a write-one-to-clear
  assign irq_evt = {state != pfsp_pkg::PFSP_ON
                      && next_state == pfsp_pkg::PFSP_ON && step_d,
                    fault_any && state != pfsp_pkg::PFSP_ERROR};

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_stat <= 2'h0;
      irq      <= 1'b0;
    end else begin
      if (wr_go && aw_addr == `PFSP_REG_IRQ_STAT && w_strb[0]) begin
        irq_stat <= (irq_stat & ~w_data[1:0]) | irq_evt;
      end else begin
        irq_stat <= irq_stat | irq_evt;
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PFSP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `PFSP_RESP_OKAY;
      unique case (s_axi_araddr)
        `PFSP_REG_CTRL:     s_axi_rdata <= {31'h0, relay_req};
        `PFSP_REG_MODE:     s_axi_rdata <= {24'h0, mode_code(state)};
        `PFSP_REG_ERR:      s_axi_rdata <= {26'h0, err};
        `PFSP_REG_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat};
        `PFSP_REG_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask};
        `PFSP_REG_START_V:  s_axi_rdata <= {16'h0, start_v};
        `PFSP_REG_VREF:     s_axi_rdata <= {16'h0, vref};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `PFSP_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : pfsp_sequencer

// ==== verif/pfsp_stage_model.sv ====
// stand-in for the pfc power stage, relay contact and converter
module pfsp_stage_model #(
  parameter int PERIOD = 8
) (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire logic                   relay_drive,
  input  wire logic                   relay_open,
  input  wire pfsp_pkg::pfsp_sample_t vals,
  output logic                        adc_done,
  output pfsp_pkg::pfsp_sample_t      adc_sample,
  output logic                        relay_closed_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // short event period keeps the 3200-event settle inside the run
  always_ff @(posedge mclk) begin
    cnt <= (sys_rst || cnt == PERIOD - 1) ? 0 : cnt + 1;
    adc_done <= !sys_rst && cnt == PERIOD - 1;
    adc_sample <= (cnt == PERIOD - 1) ? vals : ~vals;
  end
  // contact latches closed; only the bench opens it
  always_ff @(posedge mclk) begin
    if (sys_rst || relay_open) begin
      relay_closed_pin <= 1'b0;
    end else if (relay_drive) begin
      relay_closed_pin <= 1'b1;
    end
  end
endmodule : pfsp_stage_model

// ==== verif/pfsp_monitor.sv ====
// protection assertions on the sequencer ports
module pfsp_monitor (
  input wire logic                   mclk,
  input wire logic                   sys_rst,
  input wire logic                   adc_done,
  input wire pfsp_pkg::pfsp_sample_t adc_sample,
  input wire logic                   heat_ok_pin,
  input wire logic                   hw_oc_irq_pin,
  input wire logic                   relay_closed_pin,
  input wire logic                   pfc_enable,
  input wire logic                   gate_enable,
  input wire logic                   inverter_stop,
  input wire logic                   pwm_as_gpio,
  input wire logic                   pwm_gpio_level
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence heat_low_s;
    !heat_ok_pin [*4] ##0 adc_done;
  endsequence
  sequence bus_bad_s;
    adc_done && (adc_sample.vdc >= 16'h01C2 || adc_sample.vdc <= 16'h0050);
  endsequence
  sequence in_bad_s;
    adc_done && (adc_sample.vac >= 16'h0184 || adc_sample.ichp >= 16'h0013);
  endsequence
  gate_cut_a: assert property (inverter_stop |-> !gate_enable)
    else $error("gate drive on during stop");
  gpio_off_a: assert property (!pfc_enable |-> pwm_as_gpio)
    else $error("pwm pins not gpio while stopped");
  pin_low_a: assert property (pwm_as_gpio |-> !pwm_gpio_level)
    else $error("gpio pwm level not low");
  bus_limit_a: assert property (bus_bad_s |-> ##[1:5] inverter_stop)
    else $error("bus limit did not stop");
  in_limit_a: assert property (in_bad_s |-> ##[1:5] inverter_stop)
    else $error("input limit did not stop");
  heat_stop_a: assert property (heat_low_s |-> ##[1:5] inverter_stop)
    else $error("heat fault did not stop");
  hw_oc_stop_a: assert property ($rose(hw_oc_irq_pin) |->
    ##[1:8] inverter_stop) else $error("hardware overcurrent did not stop");
  start_cond_a: assert property ($rose(pfc_enable) |->
    relay_closed_pin && !inverter_stop) else $error("start without relay");
endmodule : pfsp_monitor

bind pfsp_sequencer pfsp_monitor i_mon (
  .mclk(mclk), .sys_rst(sys_rst), .adc_done(adc_done),
  .adc_sample(adc_sample), .heat_ok_pin(heat_ok_pin),
  .hw_oc_irq_pin(hw_oc_irq_pin), .relay_closed_pin(relay_closed_pin),
  .pfc_enable(pfc_enable), .gate_enable(gate_enable),
  .inverter_stop(inverter_stop), .pwm_as_gpio(pwm_as_gpio),
  .pwm_gpio_level(pwm_gpio_level)
);

// ==== verif/testbench.sv ====
// self-checking bench for the pfc sequencer and protection block
`include "pfsp_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // 230 V in, 390 V bus, 5 A
  localparam pfsp_pkg::pfsp_sample_t NOMINAL = {16'h00E6, 16'h0186, 16'h0005};
  logic mclk = 1'b0, sys_rst = 1'b1, heat_ok_pin = 1'b1, hw_oc = 1'b0;
  logic relay_open = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  pfsp_pkg::pfsp_sample_t vals = NOMINAL, adc_sample;
  logic adc_done, relay_closed, relay_drive, pfc_enable, gate_enable, irq;
  logic inverter_stop, pwm_as_gpio, pwm_level, awready, wready, bvalid;
  logic arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int n_errors = 0, checks = 0;
  always #25 mclk = ~mclk;
  pfsp_stage_model #(.PERIOD(8)) i_model (.mclk(mclk), .sys_rst(sys_rst),
    .relay_drive(relay_drive), .relay_open(relay_open), .vals(vals),
    .adc_done(adc_done), .adc_sample(adc_sample),
    .relay_closed_pin(relay_closed));
  pfsp_sequencer i_dut (.mclk(mclk), .sys_rst(sys_rst), .adc_done(adc_done),
    .adc_sample(adc_sample), .heat_ok_pin(heat_ok_pin),
    .hw_oc_irq_pin(hw_oc), .relay_closed_pin(relay_closed),
    .relay_drive(relay_drive), .pfc_enable(pfc_enable),
    .gate_enable(gate_enable), .inverter_stop(inverter_stop),
    .pwm_as_gpio(pwm_as_gpio), .pwm_gpio_level(pwm_level), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic tally_and_finish();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] e, got);
    checks++;
    if (got !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, got);
    end
  endtask : chk
  // every polling wait in the bench runs through this bound
  task automatic guard(inout int t);
    t++;
    if (t > 40000) begin
      chk("wait", 32'h1, 32'h0);
      tally_and_finish();
    end
  endtask : guard
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int t;
    t = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      guard(t);
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int t;
    t = 0;
    @(posedge mclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      guard(t);
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd
  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(what, e, d);
  endtask : rchk
  task automatic events(input int n);
    int t;
    t = 0;
    repeat (n) begin
      do begin
        @(posedge mclk);
        guard(t);
      end while (!adc_done);
    end
  endtask : events
  task automatic s_reset();
    logic [31:0] d;
    logic [1:0] r;
    chk("stop", 32'h1, {31'h0, inverter_stop & pwm_as_gpio});
    chk("idle outs", 32'h0, {31'h0, pfc_enable | relay_drive | irq});
    rchk("start_v", `PFSP_REG_START_V, 32'h172);
    rchk("mode", `PFSP_REG_MODE, 32'h0);
    rd(8'h40, d, r);
    chk("unmapped read", 32'h2, {d[29:0], r});
    wr(8'h40, 32'h1, 2'h2);
  endtask : s_reset
  task automatic s_start();
    int n;
    int t;
    n = 0;
    t = 0;
    wr(`PFSP_REG_IRQ_MASK, 32'h0, 2'h0);
    wr(`PFSP_REG_CTRL, 32'h1, 2'h0);
    while (!pfc_enable) begin
      @(posedge mclk);
      n += int'(adc_done && relay_closed);
      guard(t);
    end
    chk("settle", 32'h1, {31'h0, n >= 3200 && n <= 3202});
    rchk("mode", `PFSP_REG_MODE, 32'h2);
    chk("gpio", 32'h0, {31'h0, pwm_as_gpio});
    chk("gates on", 32'h1, {31'h0, gate_enable & ~inverter_stop});
    wr(`PFSP_REG_VREF, 32'h171, 2'h0);
    events(4);
    rchk("mode", `PFSP_REG_MODE, 32'h2);
    wr(`PFSP_REG_VREF, 32'h172, 2'h0);
    events(4);
    rchk("mode", `PFSP_REG_MODE, 32'h3);
    rchk("stat", `PFSP_REG_IRQ_STAT, 32'h2);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`PFSP_REG_IRQ_MASK, 32'h2, 2'h0);
    events(1);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`PFSP_REG_IRQ_STAT, 32'h2, 2'h0);
    wr(`PFSP_REG_IRQ_MASK, 32'h1, 2'h0);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask : s_start
  task automatic s_faults();
    for (int k = 0; k < 6; k++) begin
      case (k)
        0: vals.vac <= 16'h0184;
        1: vals.vdc <= 16'h01C2;
        2: vals.vdc <= 16'h0050;
        3: vals.ichp <= 16'h0013;
        4: hw_oc <= 1'b1;
        default: heat_ok_pin <= 1'b0;
      endcase
      events(2);
      // the stop reaches the pins and irq a few cycles after its event
      repeat (4) @(posedge mclk);
      chk("stop", 32'h1, {31'h0, inverter_stop & ~gate_enable});
      chk("pins", 32'h1, {31'h0, pwm_as_gpio & ~pwm_level});
      chk("irq", 32'h1, {31'h0, irq});
      vals <= NOMINAL;
      {heat_ok_pin, hw_oc} <= 2'h2;
      events(2);
      rchk("mode", `PFSP_REG_MODE, 32'h4);
      rchk("err", `PFSP_REG_ERR, 32'h1 << k);
      wr(`PFSP_REG_IRQ_STAT, 32'h3, 2'h0);
      rchk("stat", `PFSP_REG_IRQ_STAT, 32'h0);
      wr(`PFSP_REG_CTRL, 32'h3, 2'h0);
      events(20);
      rchk("mode", `PFSP_REG_MODE, 32'h3);
      rchk("err", `PFSP_REG_ERR, 32'h0);
    end
  endtask : s_faults
  task automatic s_relay();
    relay_open <= 1'b1;
    events(3);
    rchk("mode", `PFSP_REG_MODE, 32'h0);
    relay_open <= 1'b0;
    events(20);
    rchk("mode", `PFSP_REG_MODE, 32'h1);
  endtask : s_relay
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    s_reset();
    s_start();
    s_faults();
    s_relay();
    tally_and_finish();
  end
endmodule : testbench
